// ### common/lsc_defs.svh
// constants for the antenna supply control slave: offsets, fields, timing
// assumes inclusion by both design files, once per compile unit
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// ----------------------------------------
// slave address
// ----------------------------------------
`define LSC_ADDR_HI 6'h04

// ----------------------------------------
// data byte field positions
// ----------------------------------------
`define LSC_SEL_BIT 7
`define LSC_SR1_DCL 6
`define LSC_SR1_ISEL 5
`define LSC_SR1_ENT 4
`define LSC_SR1_LLC 3
`define LSC_SR1_VSEL 2
`define LSC_SR1_EN 1
`define LSC_SR1_OLF 0
`define LSC_SR2_EN2 2
`define LSC_SR2_OTF 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define LSC_SR1_RST 8'h00
`define LSC_SR2_RST 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define LSC_CLK_KHZ 25000
`define LSC_T_OFF_MS 900
`define LSC_T_ON_MS 20
`define LSC_LIM_CNT_W 25

`endif

// ### common/lsc_pkg.sv
// types for the antenna supply control slave
// assumes nothing beyond a SystemVerilog compiler
package lsc_pkg;

    typedef struct packed {
        logic dynamic_limit_select;
        logic current_range_select;
        logic tone_force;
        logic cable_comp_boost;
        logic high_voltage_select;
        logic output_enable_ch1;
    } lsc_ctrl_t;

    typedef enum logic [1:0] {
        LSC_LVL_13V = 2'h0,
        LSC_LVL_18V = 2'h1,
        LSC_LVL_14V = 2'h2,
        LSC_LVL_19V = 2'h3
    } lsc_level_t;

    typedef struct packed {
        logic stage_en;
        logic static_clamp;
        logic current_range;
        lsc_level_t level;
        logic tone_on;
        logic enable_second;
    } lsc_drive_t;

    typedef struct packed {
        logic [7:0] sr1;
        logic [7:0] sr2;
        logic addr_sel;
    } lsc_snap_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic power_good;
        logic tone_gate_input;
        logic addr_sel;
        logic overcurrent;
        logic thermal_shutdown;
    } lsc_pins_t;

    typedef enum logic [2:0] {
        LSC_LIM_RUN = 3'h1,
        LSC_LIM_OFF = 3'h2,
        LSC_LIM_TRY = 3'h4
    } lsc_lim_t;

    typedef enum logic [3:0] {
        LSC_LK_ADDR = 4'h1,
        LSC_LK_WR = 4'h2,
        LSC_LK_RD = 4'h4,
        LSC_LK_IGN = 4'h8
    } lsc_link_st_t;

endpackage

// ### src/lsc_i2c_link.sv
// serial engine of the control slave, clocked by the bus clock itself
// assumes link_rst_n is held low between frames by the ref_clk side
`timescale 1ns/1ps
`include "lsc_defs.svh"

module lsc_i2c_link (
    input wire logic scl_clk,
    input wire logic rst_n,
    input wire logic link_rst_n,
    input wire logic sda_i,
    input wire lsc_pkg::lsc_snap_t snap,
    output logic sda_oe,
    output logic [7:0] wr_byte,
    output logic wr_toggle
);

    lsc_pkg::lsc_link_st_t st_q;
    logic [3:0] cnt_q;
    logic [6:0] rx_q;
    logic ack_q;
    logic rw_q;
    logic rd_idx_q;
    logic [7:0] tx_byte;
    logic addr_match;

    assign tx_byte = rd_idx_q ? snap.sr2 : snap.sr1;
    assign addr_match = (rx_q[6:1] == `LSC_ADDR_HI) && (rx_q[0] == snap.addr_sel);

    // ----------------------------------------
    // bit sampling and byte state
    // ----------------------------------------
    always_ff @(posedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_q <= lsc_pkg::LSC_LK_ADDR;
            cnt_q <= 4'h0;
            rx_q <= 7'h00;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            rd_idx_q <= 1'b0;
        end else if (cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            case (st_q)
                lsc_pkg::LSC_LK_ADDR: begin
                    if (!ack_q) begin
                        st_q <= lsc_pkg::LSC_LK_IGN;
                    end else if (rw_q) begin
                        st_q <= lsc_pkg::LSC_LK_RD;
                    end else begin
                        st_q <= lsc_pkg::LSC_LK_WR;
                    end
                end
                lsc_pkg::LSC_LK_RD: begin
                    if (sda_i) begin
                        st_q <= lsc_pkg::LSC_LK_IGN;
                    end else begin
                        rd_idx_q <= ~rd_idx_q;
                    end
                end
                default: st_q <= st_q;
            endcase
        end else begin
            cnt_q <= cnt_q + 4'h1;
            rx_q <= {rx_q[5:0], sda_i};
            if (cnt_q == 4'h7) begin
                case (st_q)
                    lsc_pkg::LSC_LK_ADDR: begin
                        ack_q <= addr_match;
                        rw_q <= sda_i;
                    end
                    lsc_pkg::LSC_LK_WR: ack_q <= 1'b1;
                    default: ack_q <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // written byte handed to ref_clk side
    // ----------------------------------------
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_byte <= 8'h00;
            wr_toggle <= 1'b0;
        end else if (link_rst_n && st_q == lsc_pkg::LSC_LK_WR && cnt_q == 4'h7) begin
            wr_byte <= {rx_q, sda_i};
            wr_toggle <= ~wr_toggle;
        end
    end

    // ----------------------------------------
    // data line drive, changes while clock low
    // ----------------------------------------
    always_ff @(negedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe <= 1'b0;
        end else if (cnt_q == 4'h8) begin
            sda_oe <= ack_q;
        end else if (st_q == lsc_pkg::LSC_LK_RD) begin
            sda_oe <= ~tx_byte[3'h7 - cnt_q[2:0]];
        end else begin
            sda_oe <= 1'b0;
        end
    end

    a_read_msb_first: assert property (@(negedge scl_clk) disable iff (!link_rst_n)
        (st_q == lsc_pkg::LSC_LK_RD && cnt_q == 4'h0) |=> (sda_oe == ~$past(tx_byte[7])))
        else $error("read byte did not start with its top bit");

    a_addr_ack_match: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
        (st_q == lsc_pkg::LSC_LK_ADDR && cnt_q == 4'h7) |=> (ack_q == $past(addr_match)))
        else $error("address acknowledge does not follow the address match");

endmodule

// ### src/lsc_lnb_ctrl.sv
// control slave of the antenna supply: register pair, limiter, drive outputs
// assumes scl_clk is the master's bus clock, resetn async active low
`timescale 1ns/1ps
`include "lsc_defs.svh"

// What this block does
// - address byte with write bit 0 makes the next byte a register write
// - top bit of a written byte picks first or second register
// - both registers are all zero after power up
// - select and compensation bits form the 13/18/14/19 volt level code
// - tone follows the gate input unless tone force runs it continuously
// - limit mode bit 1 gives static clamp, 0 gives dynamic protection
// - output enable low turns the first power stage and its tone off regardless of others; the second enable ignores it
// - read address makes the device shift a register byte out, top bit first
// - master ack asks for another byte, no ack ends the read
// - writable bits read back exactly as last written
// - overload and overtemperature flags are read only
// - overload flag reads 1 while overload protection is active
// - overtemperature flag reads 1 while thermal shutdown is reported
// - supply not good: bus ignored, registers held zero, stages off
// - enable starts at 0 and never takes effect before the config bits
// - address select pin picks address 0001000 or 0001001
// - no acknowledge driven while supply is not good
// - dynamic mode: overload gives 900 ms off, 20 ms retry, clean retry clears flag
module lsc_lnb_ctrl #(
    parameter int unsigned T_OFF_CYC = `LSC_T_OFF_MS * `LSC_CLK_KHZ,
    parameter int unsigned T_ON_CYC = `LSC_T_ON_MS * `LSC_CLK_KHZ
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic power_good,
    input wire logic tone_gate_input,
    input wire logic addr_sel,
    input wire logic overcurrent_det,
    input wire logic thermal_shutdown,
    output lsc_pkg::lsc_drive_t drive
);

    localparam logic [`LSC_LIM_CNT_W-1:0] OFF_LAST = `LSC_LIM_CNT_W'(T_OFF_CYC - 1);
    localparam logic [`LSC_LIM_CNT_W-1:0] ON_LAST = `LSC_LIM_CNT_W'(T_ON_CYC - 1);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] pack_sr1(input lsc_pkg::lsc_ctrl_t c, input logic olf);
        logic [7:0] b;
        b = `LSC_SR1_RST;
        b[`LSC_SR1_DCL] = c.dynamic_limit_select;
        b[`LSC_SR1_ISEL] = c.current_range_select;
        b[`LSC_SR1_ENT] = c.tone_force;
        b[`LSC_SR1_LLC] = c.cable_comp_boost;
        b[`LSC_SR1_VSEL] = c.high_voltage_select;
        b[`LSC_SR1_EN] = c.output_enable_ch1;
        b[`LSC_SR1_OLF] = olf;
        return b;
    endfunction

    function automatic logic [7:0] pack_sr2(input logic en2, input logic overtemp_flag);
        logic [7:0] b;
        b = `LSC_SR2_RST;
        b[`LSC_SR2_EN2] = en2;
        b[`LSC_SR2_OTF] = overtemp_flag;
        return b;
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    lsc_pkg::lsc_pins_t pins_raw;
    lsc_pkg::lsc_pins_t s1_q;
    lsc_pkg::lsc_pins_t s2_q;
    logic sda_p_q;
    logic start_ev;
    logic stop_ev;
    logic frame_q;
    logic hold_q;
    logic link_rst_n;
    lsc_pkg::lsc_snap_t snap_q;
    logic [7:0] wr_byte;
    logic wr_toggle;
    logic wt1_q;
    logic wt2_q;
    logic wt3_q;
    logic wr_ev;
    lsc_pkg::lsc_ctrl_t ctrl_q;
    logic en2_q;
    lsc_pkg::lsc_lim_t lim_q;
    logic [`LSC_LIM_CNT_W-1:0] lim_cnt_q;
    logic olf_dyn_q;
    logic olf;
    logic overtemp_flag;
    logic stage_en_d;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    assign pins_raw = '{scl: scl_clk, sda: sda_i, power_good: power_good,
                        tone_gate_input: tone_gate_input, addr_sel: addr_sel,
                        overcurrent: overcurrent_det, thermal_shutdown: thermal_shutdown};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            sda_p_q <= 1'b1;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            sda_p_q <= s2_q.sda;
        end
    end

    // ----------------------------------------
    // frame detection and engine hold
    // ----------------------------------------
    assign start_ev = s2_q.scl && sda_p_q && !s2_q.sda;
    assign stop_ev = s2_q.scl && !sda_p_q && s2_q.sda;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            frame_q <= 1'b0;
        end else if (start_ev) begin
            frame_q <= 1'b1;
        end else if (stop_ev) begin
            frame_q <= 1'b0;
        end
    end

    // engine held in reset between frames and while supply is not good
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 1'b1;
        end else if (start_ev || stop_ev || !s2_q.power_good) begin
            hold_q <= 1'b1;
        end else if (frame_q && !s2_q.scl) begin
            hold_q <= 1'b0;
        end
    end

    assign link_rst_n = resetn && !hold_q;

    // read image refreshed while the engine is held, frozen while it runs a frame
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            snap_q <= '0;
        end else if (hold_q) begin
            snap_q.sr1 <= pack_sr1(ctrl_q, olf);
            snap_q.sr2 <= pack_sr2(en2_q, overtemp_flag);
            snap_q.addr_sel <= s2_q.addr_sel;
        end
    end

    // ----------------------------------------
    // serial engine on the bus clock
    // ----------------------------------------
    lsc_i2c_link u_link (
        .scl_clk(scl_clk),
        .rst_n(resetn),
        .link_rst_n(link_rst_n),
        .sda_i(sda_i),
        .snap(snap_q),
        .sda_oe(sda_oe),
        .wr_byte(wr_byte),
        .wr_toggle(wr_toggle)
    );

    assign sda_o = 1'b0;

    // ----------------------------------------
    // write event crossing
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wt1_q <= 1'b0;
            wt2_q <= 1'b0;
            wt3_q <= 1'b0;
        end else begin
            wt1_q <= wr_toggle;
            wt2_q <= wt1_q;
            wt3_q <= wt2_q;
        end
    end

    assign wr_ev = wt2_q ^ wt3_q;

    // ----------------------------------------
    // register pair
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= '0;
            en2_q <= 1'b0;
        end else if (!s2_q.power_good) begin
            ctrl_q <= '0;
            en2_q <= 1'b0;
        end else if (wr_ev) begin
            if (!wr_byte[`LSC_SEL_BIT]) begin
                ctrl_q.dynamic_limit_select <= wr_byte[`LSC_SR1_DCL];
                ctrl_q.current_range_select <= wr_byte[`LSC_SR1_ISEL];
                ctrl_q.tone_force <= wr_byte[`LSC_SR1_ENT];
                ctrl_q.cable_comp_boost <= wr_byte[`LSC_SR1_LLC];
                ctrl_q.high_voltage_select <= wr_byte[`LSC_SR1_VSEL];
                ctrl_q.output_enable_ch1 <= wr_byte[`LSC_SR1_EN];
            end else begin
                en2_q <= wr_byte[`LSC_SR2_EN2];
            end
        end
    end

    // ----------------------------------------
    // dynamic overload limiter
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lim_q <= lsc_pkg::LSC_LIM_RUN;
            lim_cnt_q <= '0;
            olf_dyn_q <= 1'b0;
        end else if (ctrl_q.dynamic_limit_select || !ctrl_q.output_enable_ch1) begin
            lim_q <= lsc_pkg::LSC_LIM_RUN;
            lim_cnt_q <= '0;
            olf_dyn_q <= 1'b0;
        end else begin
            case (lim_q)
                lsc_pkg::LSC_LIM_RUN: begin
                    if (s2_q.overcurrent) begin
                        lim_q <= lsc_pkg::LSC_LIM_OFF;
                        lim_cnt_q <= '0;
                        olf_dyn_q <= 1'b1;
                    end
                end
                lsc_pkg::LSC_LIM_OFF: begin
                    if (lim_cnt_q == OFF_LAST) begin
                        lim_q <= lsc_pkg::LSC_LIM_TRY;
                        lim_cnt_q <= '0;
                    end else begin
                        lim_cnt_q <= lim_cnt_q + 1'b1;
                    end
                end
                lsc_pkg::LSC_LIM_TRY: begin
                    if (lim_cnt_q != ON_LAST) begin
                        lim_cnt_q <= lim_cnt_q + 1'b1;
                    end else if (s2_q.overcurrent) begin
                        lim_q <= lsc_pkg::LSC_LIM_OFF;
                        lim_cnt_q <= '0;
                    end else begin
                        lim_q <= lsc_pkg::LSC_LIM_RUN;
                        lim_cnt_q <= '0;
                        olf_dyn_q <= 1'b0;
                    end
                end
                default: begin
                    lim_q <= lsc_pkg::LSC_LIM_RUN;
                    lim_cnt_q <= '0;
                    olf_dyn_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // diagnostic flags
    // ----------------------------------------
    assign olf = ctrl_q.dynamic_limit_select ? s2_q.overcurrent : olf_dyn_q;
    assign overtemp_flag = s2_q.thermal_shutdown;

    // ----------------------------------------
    // drive outputs, all from one register
    // ----------------------------------------
    assign stage_en_d = ctrl_q.output_enable_ch1 && s2_q.power_good && !overtemp_flag
                        && (lim_q != lsc_pkg::LSC_LIM_OFF);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive <= '0;
        end else begin
            drive.stage_en <= stage_en_d;
            drive.static_clamp <= ctrl_q.dynamic_limit_select;
            drive.current_range <= ctrl_q.current_range_select;
            drive.level <= lsc_pkg::lsc_level_t'({ctrl_q.cable_comp_boost,
                                                  ctrl_q.high_voltage_select});
            drive.tone_on <= stage_en_d && (ctrl_q.tone_force || s2_q.tone_gate_input);
            drive.enable_second <= en2_q && s2_q.power_good;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_pwr_clears_regs: assert property (
        !s2_q.power_good |=> (ctrl_q == '0 && !en2_q && hold_q) ##1 !drive.stage_en)
        else $error("registers or stages not cleared without supply");

    a_no_ack_unpowered: assert property (hold_q |-> !sda_oe)
        else $error("data line driven while engine held");

    a_enable_low_off: assert property (
        !ctrl_q.output_enable_ch1 |=> !drive.stage_en && !drive.tone_on)
        else $error("stages on with output enable low");

    a_write_first_reg: assert property (
        (wr_ev && s2_q.power_good && !wr_byte[7]) |=>
        (ctrl_q == $past(wr_byte[6:1]) && $stable(en2_q)))
        else $error("first register write not stored");

    a_write_second_reg: assert property (
        (wr_ev && s2_q.power_good && wr_byte[7]) |=>
        (en2_q == $past(wr_byte[2]) && $stable(ctrl_q)))
        else $error("second register write disturbed other bits");

    a_level_code: assert property (
        ##1 (drive.level == $past({ctrl_q.cable_comp_boost, ctrl_q.high_voltage_select})))
        else $error("level code does not follow its bits");

    a_tone_forced: assert property (
        (ctrl_q.tone_force && stage_en_d) |=> drive.tone_on)
        else $error("forced tone not running");

    a_static_flag: assert property (
        (ctrl_q.dynamic_limit_select && hold_q) |=>
        (snap_q.sr1[`LSC_SR1_OLF] == $past(s2_q.overcurrent)))
        else $error("static overload flag does not track detector");

    a_dyn_off_hold: assert property (
        (lim_q == lsc_pkg::LSC_LIM_OFF && lim_cnt_q != OFF_LAST && !ctrl_q.dynamic_limit_select
         && ctrl_q.output_enable_ch1) |=> (lim_q == lsc_pkg::LSC_LIM_OFF && olf_dyn_q
         && !drive.stage_en))
        else $error("dynamic off period ended early");

    a_snap_readback: assert property (
        (hold_q && $stable(ctrl_q) && $stable(olf)) |=>
        (snap_q.sr1 == $past(pack_sr1(ctrl_q, olf))))
        else $error("read image differs from stored bits");

    c_write_first: cover property (wr_ev && !wr_byte[7]);
    c_write_second: cover property (wr_ev && wr_byte[7]);
    c_read_drive: cover property (!hold_q ##1 sda_oe);
    c_dyn_off: cover property (lim_q == lsc_pkg::LSC_LIM_OFF);

endmodule

// ### bench/lsc_host_model.sv
// bus master model that drives the control slave over scl and sda
// assumes the bench resolves sda from both enables with a pull-up
`timescale 1ns/1ps
module lsc_host_model #(
    parameter int HALF = 1260
) (
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    // ----------------------------------------
    // bit, byte and frame level
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_oe = !b;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF / 2);
        r = sda;
        #(HALF / 2);
        scl = 1'b0;
        #(HALF / 2);
    endtask
    task automatic start_c;
        sda_oe = 1'b1;
        #(HALF);
        scl = 1'b0;
        #(HALF / 2);
    endtask
    task automatic stop_c;
        sda_oe = 1'b1;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF);
        sda_oe = 1'b0;
        #(HALF);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic sack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(!mack, sack);
        sack = !sack;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic ack);
        logic [7:0] rx;
        logic k;
        start_c();
        xfer({a, 1'b0}, 1'b0, rx, ack);
        xfer(d, 1'b0, rx, k);
        stop_c();
    endtask
    task automatic rd(input logic [6:0] a, output logic ack, output logic [7:0] b1,
                      output logic [7:0] b2);
        logic k;
        start_c();
        xfer({a, 1'b1}, 1'b0, b1, ack);
        xfer(8'hFF, 1'b1, b1, k);
        xfer(8'hFF, 1'b0, b2, k);
        stop_c();
    endtask
endmodule

// ### bench/lsc_lnb_ctrl_tb.sv
// self-checking bench of the antenna supply control slave
// assumes the host model and the design with short limiter counts
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module lsc_lnb_ctrl_tb;
    localparam int T_OFF = 200;
    localparam int T_ON = 50;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic host_oe;
    logic dev_oe;
    logic dev_o;
    logic sda;
    logic power_good = 1'b1;
    logic tone_gate = 1'b0;
    logic addr_sel = 1'b0;
    logic oc = 1'b0;
    logic hot = 1'b0;
    lsc_pkg::lsc_drive_t drive;
    int num_errors = 0;
    int n_compared = 0;
    logic ack;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [8:0] rows [8] = '{9'h002, 9'h006, 9'h00A, 9'h00E, 9'h102, 9'h012, 9'h07F, 9'h07C};
    // ----------------------------------------
    // clock, line and instances
    // ----------------------------------------
    always #20 ref_clk = ~ref_clk;
    assign sda = !(host_oe || (dev_oe && !dev_o));
    lsc_host_model i_lsc_host_model (.scl(scl), .sda_oe(host_oe), .sda(sda));
    lsc_lnb_ctrl #(.T_OFF_CYC(T_OFF), .T_ON_CYC(T_ON)) i_lsc_lnb_ctrl (
        .ref_clk(ref_clk), .resetn(resetn), .scl_clk(scl), .sda_i(sda), .sda_o(dev_o),
        .sda_oe(dev_oe), .power_good(power_good), .tone_gate_input(tone_gate),
        .addr_sel(addr_sel), .overcurrent_det(oc), .thermal_shutdown(hot), .drive(drive));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    function automatic lsc_pkg::lsc_drive_t exp_drv(logic g, logic [7:0] d);
        return {d[1], d[6], d[5], d[3], d[2], d[1] & (d[4] | g), 1'b0};
    endfunction
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        num_errors++;
        $display("[ERR] %0t run too long", $time);
        close_out();
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        tick(5);
        resetn = 1'b1;
        tick(5);
        `CHK(drive, 7'h00)
        i_lsc_host_model.rd(7'h08, ack, b1, b2);
        `CHK({ack, b1, b2}, 17'h10000)
        $display("reset test done");
        tick(1);
        addr_sel = 1'b1;
        tick(5);
        i_lsc_host_model.wr(7'h08, 8'h02, ack);
        `CHK(ack, 1'b0)
        i_lsc_host_model.rd(7'h09, ack, b1, b2);
        `CHK({ack, b1}, 9'h100)
        tick(1);
        addr_sel = 1'b0;
        tick(5);
        $display("address test done");
        foreach (rows[i]) begin
            tick(1);
            tone_gate = rows[i][8];
            i_lsc_host_model.wr(7'h08, rows[i][7:0], ack);
            `CHK(ack, 1'b1)
            tick(10);
            `CHK(drive, exp_drv(rows[i][8], rows[i][7:0]))
            i_lsc_host_model.rd(7'h08, ack, b1, b2);
            `CHK(b1, rows[i][7:0] & 8'h7E)
            `CHK(b2, 8'h00)
        end
        $display("table test done");
        i_lsc_host_model.wr(7'h08, 8'h02, ack);
        tick(1);
        oc = 1'b1;
        tick(10);
        `CHK(drive.stage_en, 1'b0)
        i_lsc_host_model.rd(7'h08, ack, b1, b2);
        `CHK(b1, 8'h03)
        tick(1);
        oc = 1'b0;
        tick(2 * (T_OFF + T_ON) + 20);
        `CHK(drive.stage_en, 1'b1)
        i_lsc_host_model.rd(7'h08, ack, b1, b2);
        `CHK(b1, 8'h02)
        $display("limiter test done");
        i_lsc_host_model.wr(7'h08, 8'hFF, ack);
        tick(1);
        hot = 1'b1;
        tick(10);
        `CHK(drive.enable_second, 1'b1)
        `CHK(drive.stage_en, 1'b0)
        i_lsc_host_model.rd(7'h08, ack, b1, b2);
        `CHK({b1, b2}, 16'h0206)
        tick(1);
        hot = 1'b0;
        tick(10);
        `CHK(drive.stage_en, 1'b1)
        $display("second register test done");
        power_good = 1'b0;
        tick(5);
        `CHK(drive, 7'h00)
        i_lsc_host_model.wr(7'h08, 8'h02, ack);
        `CHK(ack, 1'b0)
        tick(1);
        power_good = 1'b1;
        tick(5);
        i_lsc_host_model.rd(7'h08, ack, b1, b2);
        `CHK({ack, b1, b2}, 17'h10000)
        $display("supply test done");
        close_out();
    end
endmodule
